// ### rtl/scm_consts.svh
// Constants for the statistics counter inhibit block
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH
`define SCM_MASK_OFFSET    8'h9C
`define SCM_TCP_OFFSET     8'hA0
`define SCM_MASK_USED      24
`define SCM_MASK_RESET     24'h000000
`define SCM_TCP_RESET      16'h0000
`define SCM_TCP_NEAR_FULL  16'hC000
`define SCM_TCP_BIT        4
`define SCM_TCP_MAX        16'hFFFF
`define SCM_BIT_RX_GOOD    0
`define SCM_BIT_RX_MCAST   1
`define SCM_BIT_RX_BCAST   2
`define SCM_BIT_RX_OVER    3
`define SCM_BIT_IP         5
`define SCM_BIT_UDP        6
`define SCM_BIT_RX_CTL     7
`define SCM_BIT_RX_LONG    8
`define SCM_BIT_RX_LEN     9
`define SCM_BIT_RX_FCS     10
`define SCM_BIT_RX_DROP    11
`define SCM_BIT_TX_GOOD    12
`define SCM_BIT_TX_MCAST   13
`define SCM_BIT_TX_BCAST   14
`define SCM_BIT_TX_DEFER   15
`define SCM_BIT_LATE_COLL  16
`define SCM_BIT_MULTI_COLL 17
`define SCM_BIT_ONE_COLL   18
`define SCM_BIT_TX_OVER    19
`define SCM_BIT_CARRIER    20
`define SCM_BIT_TX_CTL     21
`define SCM_BIT_ABORT_COLL 22
`define SCM_BIT_EXC_DEFER  23
`endif

// ### rtl/scm_pkg.sv
// Types for the statistics counter inhibit block
package scm_pkg;
    typedef struct packed {
        logic [23:0] mask;
        logic [15:0] tcp_count;
        logic [23:0] inc_ok;
        logic        update_flag;
        logic [31:0] rdata;
    } scm_state_t;
endpackage

// ### rtl/scm_stats_mask.sv
// Statistics counter inhibit mask and TCP checksum failure counter
`timescale 1ns/1ps
`include "scm_consts.svh"
module scm_stats_mask
    import scm_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Register access
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    // Control and events
    input  wire logic        stats_global_enable,
    input  wire logic [23:0] count_event,
    input  wire logic        update_flag_clear,
    // Qualified increments and status
    output logic      [23:0] count_inc_ok,
    output logic      [15:0] tcp_sum_fail_count,
    output logic      [23:0] counter_inhibit_mask,
    output logic             update_stats_flag
);
    scm_state_t st;
    scm_state_t next_st;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Each event passes only when enabled and its own mask bit is clear
        next_st.inc_ok = count_event & ~st.mask & {24{stats_global_enable}};
        if (reg_wr && reg_addr == `SCM_MASK_OFFSET) begin
            next_st.mask = reg_wdata[23:0];
        end
        if (reg_wr && reg_addr == `SCM_TCP_OFFSET) begin
            next_st.tcp_count = reg_wdata[15:0];
        end else if (count_event[`SCM_TCP_BIT] && stats_global_enable && !st.mask[`SCM_TCP_BIT]) begin
            next_st.tcp_count = st.tcp_count + 16'h0001;
        end
        if (update_flag_clear) begin
            next_st.update_flag = 1'b0;
        end
        // Set wins over clear
        if (next_st.tcp_count == `SCM_TCP_NEAR_FULL && st.tcp_count != `SCM_TCP_NEAR_FULL) begin
            next_st.update_flag = 1'b1;
        end
        next_st.rdata = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                `SCM_MASK_OFFSET: next_st.rdata = {8'h00, st.mask};
                `SCM_TCP_OFFSET:  next_st.rdata = {16'h0000, st.tcp_count};
                default:          next_st.rdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            st.mask        <= `SCM_MASK_RESET;
            st.tcp_count   <= `SCM_TCP_RESET;
            st.inc_ok      <= 24'h000000;
            st.update_flag <= 1'b0;
            st.rdata       <= 32'h00000000;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata            = st.rdata;
    assign count_inc_ok         = st.inc_ok;
    assign tcp_sum_fail_count   = st.tcp_count;
    assign counter_inhibit_mask = st.mask;
    assign update_stats_flag    = st.update_flag;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_tcp_event;
        count_event[`SCM_TCP_BIT] && stats_global_enable && !st.mask[`SCM_TCP_BIT] && !(reg_wr && reg_addr == `SCM_TCP_OFFSET);
    endsequence

    a_masked_blocks: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> ((count_inc_ok & $past(counter_inhibit_mask)) == 24'h000000))
        else $error("masked event passed");
    a_disable_blocks: assert property (@(posedge clk) disable iff (srst)
        !stats_global_enable |=> count_inc_ok == 24'h000000)
        else $error("event passed while disabled");
    a_event_passes: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_TX_GOOD] && !counter_inhibit_mask[`SCM_BIT_TX_GOOD]) |=>
        count_inc_ok[`SCM_BIT_TX_GOOD])
        else $error("enabled event lost");
    a_tcp_counts: assert property (@(posedge clk) disable iff (srst)
        s_tcp_event |=> tcp_sum_fail_count == $past(tcp_sum_fail_count) + 16'h0001)
        else $error("tcp counter did not step");
    a_tcp_holds: assert property (@(posedge clk) disable iff (srst)
        (counter_inhibit_mask[4] && !reg_wr) |=> $stable(tcp_sum_fail_count))
        else $error("masked tcp counter moved");
    a_tcp_wraps: assert property (@(posedge clk) disable iff (srst)
        (s_tcp_event and tcp_sum_fail_count == `SCM_TCP_MAX) |=> tcp_sum_fail_count == 16'h0000)
        else $error("tcp counter did not wrap");
    a_near_full_flag: assert property (@(posedge clk) disable iff (srst)
        (s_tcp_event and tcp_sum_fail_count == (`SCM_TCP_NEAR_FULL - 16'h0001)) |=> update_stats_flag)
        else $error("update flag not raised");
    a_reserved_zero: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> reg_rdata[31:24] == 8'h00)
        else $error("reserved bits nonzero");

    // ------------------------------------------------------------
    // Receive counter masks
    // ------------------------------------------------------------
    a_rx_good_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_RX_GOOD] |=> !count_inc_ok[`SCM_BIT_RX_GOOD])
        else $error("rx good pair not held");
    a_rx_good_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_RX_GOOD] && !counter_inhibit_mask[`SCM_BIT_RX_GOOD]) |=>
        count_inc_ok[`SCM_BIT_RX_GOOD])
        else $error("rx good event lost");

    a_rx_mcast_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_RX_MCAST] |=> !count_inc_ok[`SCM_BIT_RX_MCAST])
        else $error("rx multicast pair not held");
    a_rx_mcast_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_RX_MCAST] && !counter_inhibit_mask[`SCM_BIT_RX_MCAST]) |=>
        count_inc_ok[`SCM_BIT_RX_MCAST])
        else $error("rx multicast event lost");

    a_rx_bcast_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_RX_BCAST] |=> !count_inc_ok[`SCM_BIT_RX_BCAST])
        else $error("rx broadcast pair not held");
    a_rx_bcast_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_RX_BCAST] && !counter_inhibit_mask[`SCM_BIT_RX_BCAST]) |=>
        count_inc_ok[`SCM_BIT_RX_BCAST])
        else $error("rx broadcast event lost");

    a_rx_over_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_RX_OVER] |=> !count_inc_ok[`SCM_BIT_RX_OVER])
        else $error("rx oversize counter not held");
    a_rx_over_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_RX_OVER] && !counter_inhibit_mask[`SCM_BIT_RX_OVER]) |=>
        count_inc_ok[`SCM_BIT_RX_OVER])
        else $error("rx oversize event lost");

    a_tcp_fail_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_TCP_BIT] |=> !count_inc_ok[`SCM_TCP_BIT])
        else $error("tcp failure counter not held");
    a_tcp_fail_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_TCP_BIT] && !counter_inhibit_mask[`SCM_TCP_BIT]) |=>
        count_inc_ok[`SCM_TCP_BIT])
        else $error("tcp failure event lost");
    a_ip_fail_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_IP] |=> !count_inc_ok[`SCM_BIT_IP])
        else $error("ip failure counter not held");
    a_ip_fail_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_IP] && !counter_inhibit_mask[`SCM_BIT_IP]) |=>
        count_inc_ok[`SCM_BIT_IP])
        else $error("ip failure event lost");
    a_udp_fail_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_UDP] |=> !count_inc_ok[`SCM_BIT_UDP])
        else $error("udp failure counter not held");
    a_udp_fail_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_UDP] && !counter_inhibit_mask[`SCM_BIT_UDP]) |=>
        count_inc_ok[`SCM_BIT_UDP])
        else $error("udp failure event lost");

    a_rx_ctl_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_RX_CTL] |=> !count_inc_ok[`SCM_BIT_RX_CTL])
        else $error("rx control counter not held");
    a_rx_ctl_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_RX_CTL] && !counter_inhibit_mask[`SCM_BIT_RX_CTL]) |=>
        count_inc_ok[`SCM_BIT_RX_CTL])
        else $error("rx control event lost");

    a_rx_long_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_RX_LONG] |=> !count_inc_ok[`SCM_BIT_RX_LONG])
        else $error("overlength counter not held");
    a_rx_long_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_RX_LONG] && !counter_inhibit_mask[`SCM_BIT_RX_LONG]) |=>
        count_inc_ok[`SCM_BIT_RX_LONG])
        else $error("overlength event lost");
    a_rx_len_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_RX_LEN] |=> !count_inc_ok[`SCM_BIT_RX_LEN])
        else $error("length error counter not held");
    a_rx_len_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_RX_LEN] && !counter_inhibit_mask[`SCM_BIT_RX_LEN]) |=>
        count_inc_ok[`SCM_BIT_RX_LEN])
        else $error("length error event lost");
    a_rx_fcs_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_RX_FCS] |=> !count_inc_ok[`SCM_BIT_RX_FCS])
        else $error("fcs error counter not held");
    a_rx_fcs_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_RX_FCS] && !counter_inhibit_mask[`SCM_BIT_RX_FCS]) |=>
        count_inc_ok[`SCM_BIT_RX_FCS])
        else $error("fcs error event lost");
    a_rx_drop_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_RX_DROP] |=> !count_inc_ok[`SCM_BIT_RX_DROP])
        else $error("dropped frame counter not held");
    a_rx_drop_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_RX_DROP] && !counter_inhibit_mask[`SCM_BIT_RX_DROP]) |=>
        count_inc_ok[`SCM_BIT_RX_DROP])
        else $error("dropped frame event lost");

    // ------------------------------------------------------------
    // Transmit counter masks
    // ------------------------------------------------------------
    a_tx_good_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_TX_GOOD] |=> !count_inc_ok[`SCM_BIT_TX_GOOD])
        else $error("tx good pair not held");

    a_tx_mcast_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_TX_MCAST] |=> !count_inc_ok[`SCM_BIT_TX_MCAST])
        else $error("tx multicast pair not held");
    a_tx_mcast_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_TX_MCAST] && !counter_inhibit_mask[`SCM_BIT_TX_MCAST]) |=>
        count_inc_ok[`SCM_BIT_TX_MCAST])
        else $error("tx multicast event lost");
    a_tx_bcast_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_TX_BCAST] |=> !count_inc_ok[`SCM_BIT_TX_BCAST])
        else $error("tx broadcast pair not held");
    a_tx_bcast_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_TX_BCAST] && !counter_inhibit_mask[`SCM_BIT_TX_BCAST]) |=>
        count_inc_ok[`SCM_BIT_TX_BCAST])
        else $error("tx broadcast event lost");

    a_tx_defer_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_TX_DEFER] |=> !count_inc_ok[`SCM_BIT_TX_DEFER])
        else $error("deferred counter not held");
    a_tx_defer_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_TX_DEFER] && !counter_inhibit_mask[`SCM_BIT_TX_DEFER]) |=>
        count_inc_ok[`SCM_BIT_TX_DEFER])
        else $error("deferred event lost");

    a_late_coll_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_LATE_COLL] |=> !count_inc_ok[`SCM_BIT_LATE_COLL])
        else $error("late collision counter not held");
    a_late_coll_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_LATE_COLL] && !counter_inhibit_mask[`SCM_BIT_LATE_COLL]) |=>
        count_inc_ok[`SCM_BIT_LATE_COLL])
        else $error("late collision event lost");
    a_multi_coll_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_MULTI_COLL] |=> !count_inc_ok[`SCM_BIT_MULTI_COLL])
        else $error("multi collision counter not held");
    a_multi_coll_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_MULTI_COLL] && !counter_inhibit_mask[`SCM_BIT_MULTI_COLL]) |=>
        count_inc_ok[`SCM_BIT_MULTI_COLL])
        else $error("multi collision event lost");
    a_one_coll_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_ONE_COLL] |=> !count_inc_ok[`SCM_BIT_ONE_COLL])
        else $error("single collision counter not held");
    a_one_coll_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_ONE_COLL] && !counter_inhibit_mask[`SCM_BIT_ONE_COLL]) |=>
        count_inc_ok[`SCM_BIT_ONE_COLL])
        else $error("single collision event lost");

    a_tx_over_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_TX_OVER] |=> !count_inc_ok[`SCM_BIT_TX_OVER])
        else $error("tx oversize counter not held");
    a_tx_over_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_TX_OVER] && !counter_inhibit_mask[`SCM_BIT_TX_OVER]) |=>
        count_inc_ok[`SCM_BIT_TX_OVER])
        else $error("tx oversize event lost");

    a_carrier_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_CARRIER] |=> !count_inc_ok[`SCM_BIT_CARRIER])
        else $error("carrier loss counter not held");
    a_carrier_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_CARRIER] && !counter_inhibit_mask[`SCM_BIT_CARRIER]) |=>
        count_inc_ok[`SCM_BIT_CARRIER])
        else $error("carrier loss event lost");

    a_tx_ctl_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_TX_CTL] |=> !count_inc_ok[`SCM_BIT_TX_CTL])
        else $error("tx control counter not held");
    a_tx_ctl_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_TX_CTL] && !counter_inhibit_mask[`SCM_BIT_TX_CTL]) |=>
        count_inc_ok[`SCM_BIT_TX_CTL])
        else $error("tx control event lost");

    a_abort_coll_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_ABORT_COLL] |=> !count_inc_ok[`SCM_BIT_ABORT_COLL])
        else $error("collision abort counter not held");
    a_abort_coll_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_ABORT_COLL] && !counter_inhibit_mask[`SCM_BIT_ABORT_COLL]) |=>
        count_inc_ok[`SCM_BIT_ABORT_COLL])
        else $error("collision abort event lost");
    a_exc_defer_held: assert property (@(posedge clk) disable iff (srst)
        counter_inhibit_mask[`SCM_BIT_EXC_DEFER] |=> !count_inc_ok[`SCM_BIT_EXC_DEFER])
        else $error("excess deferral counter not held");
    a_exc_defer_pass: assert property (@(posedge clk) disable iff (srst)
        (stats_global_enable && count_event[`SCM_BIT_EXC_DEFER] && !counter_inhibit_mask[`SCM_BIT_EXC_DEFER]) |=>
        count_inc_ok[`SCM_BIT_EXC_DEFER])
        else $error("excess deferral event lost");

    // ------------------------------------------------------------
    // Counter, flag and register access
    // ------------------------------------------------------------
    sequence s_tcp_write;
        reg_wr && reg_addr == `SCM_TCP_OFFSET;
    endsequence

    a_tcp_idle_hold: assert property (@(posedge clk) disable iff (srst)
        (!stats_global_enable && !(reg_wr && reg_addr == `SCM_TCP_OFFSET)) |=> $stable(tcp_sum_fail_count))
        else $error("disabled tcp counter moved");
    a_write_wins: assert property (@(posedge clk) disable iff (srst)
        s_tcp_write |=> tcp_sum_fail_count == $past(reg_wdata[15:0]))
        else $error("counter write lost");
    a_mask_write: assert property (@(posedge clk) disable iff (srst)
        (reg_wr && reg_addr == `SCM_MASK_OFFSET) |=> counter_inhibit_mask == $past(reg_wdata[23:0]))
        else $error("mask write lost");
    a_mask_readback: assert property (@(posedge clk) disable iff (srst)
        (reg_rd && reg_addr == `SCM_MASK_OFFSET) |=> reg_rdata == {8'h00, $past(counter_inhibit_mask)})
        else $error("mask read data wrong");
    a_count_readback: assert property (@(posedge clk) disable iff (srst)
        (reg_rd && reg_addr == `SCM_TCP_OFFSET) |=> reg_rdata == {16'h0000, $past(tcp_sum_fail_count)})
        else $error("counter read data wrong");
    a_rdata_idle: assert property (@(posedge clk) disable iff (srst)
        !reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data without read");
    a_inc_needs_event: assert property (@(posedge clk) disable iff (srst)
        (count_event == 24'h000000) |=> count_inc_ok == 24'h000000)
        else $error("increment without event");
    a_flag_sticky: assert property (@(posedge clk) disable iff (srst)
        (update_stats_flag && !update_flag_clear) |=> update_stats_flag)
        else $error("update flag dropped");
    a_flag_cleared: assert property (@(posedge clk) disable iff (srst)
        (update_flag_clear && !count_event[`SCM_TCP_BIT] && !reg_wr) |=> !update_stats_flag)
        else $error("update flag not cleared");
endmodule // scm_stats_mask

// ### testbench/test_scm_stats_mask.sv
// Self-checking bench for the statistics counter inhibit block
`timescale 1ns/1ps
module test_scm_stats_mask;
    logic        clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, en = 1'b1, clr = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [23:0] ev = 24'h0, inc_ok, mask;
    logic [15:0] tcp;
    logic        flag;
    int          error_cnt = 0, tests_run = 0;
    always #4 clk = ~clk;
    scm_stats_mask i_dut (.clk(clk), .srst(srst), .reg_addr(addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(wdata), .reg_rdata(rdata), .stats_global_enable(en), .count_event(ev),
        .update_flag_clear(clr), .count_inc_ok(inc_ok), .tcp_sum_fail_count(tcp),
        .counter_inhibit_mask(mask), .update_stats_flag(flag));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) #1;
        addr   = a;
        wdata  = d;
        reg_wr = 1'b1;
        @(posedge clk) #1;
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk) #1;
        addr   = a;
        reg_rd = 1'b1;
        @(posedge clk) #1;
        reg_rd = 1'b0;
        chk(what, exp, rdata);
    endtask
    // One cycle of increment requests, then the qualified increments
    task automatic pulse(input logic [23:0] e, input logic [23:0] exp);
        @(posedge clk) #1;
        ev = e;
        @(posedge clk) #1;
        ev = 24'h0;
        chk("count_inc_ok", {8'h00, exp}, {8'h00, inc_ok});
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1 srst = 1'b0;
        rd(8'h9C, 32'h0, "mask reset");
        rd(8'hA0, 32'h0, "count reset");
        wr(8'h9C, 32'hFFFFFFFF);
        chk("counter_inhibit_mask", 32'h00FFFFFF, {8'h00, mask});
        rd(8'h9C, 32'h00FFFFFF, "mask upper bits");
        rd(8'h44, 32'h0, "unmapped read");
        for (int n = 0; n < 24; n++) begin
            wr(8'h9C, 32'h1 << n);
            pulse(24'hFFFFFF, ~(24'h1 << n)); // to
        end
        rd(8'hA0, 32'h00000017, "count after sweep");
        wr(8'h9C, 32'h10);
        pulse(24'h10, 24'h0);
        rd(8'hA0, 32'h00000017, "count held");
        wr(8'h9C, 32'h0);
        en = 1'b0;
        pulse(24'h10, 24'h0);
        en = 1'b1;
        pulse(24'h10, 24'h10);
        rd(8'hA0, 32'h00000018, "count resumed");
        wr(8'hA0, 32'hBFFF);
        pulse(24'h10, 24'h10);
        rd(8'hA0, 32'hC000, "count near full");
        chk("tcp_sum_fail_count", 32'h0000C000, {16'h0000, tcp});
        chk("update flag set", 32'h1, {31'h0, flag});
        clr = 1'b1;
        @(posedge clk) #1;
        clr = 1'b0;
        wr(8'hA0, 32'hFFFF);
        chk("update flag cleared", 32'h0, {31'h0, flag});
        pulse(24'h10, 24'h10);
        rd(8'hA0, 32'h0, "count wrap");
        // Event and clear in one cycle: the set wins
        wr(8'hA0, 32'hBFFF);
        @(posedge clk) #1;
        ev  = 24'h10;
        clr = 1'b1;
        @(posedge clk) #1;
        ev  = 24'h0;
        clr = 1'b0;
        chk("update flag set wins", 32'h1, {31'h0, flag});
        // Counter write and increment in one cycle: the write wins
        @(posedge clk) #1;
        addr   = 8'hA0;
        wdata  = 32'h1234;
        reg_wr = 1'b1;
        ev     = 24'h10;
        @(posedge clk) #1;
        reg_wr = 1'b0;
        ev     = 24'h0;
        chk("tcp_sum_fail_count write wins", 32'h1234, {16'h0000, tcp});
        wr(8'h9C, 32'hF0F);
        // Reset in mid-run
        @(posedge clk) #1;
        srst = 1'b1;
        @(posedge clk) #1;
        srst = 1'b0;
        chk("counter_inhibit_mask after reset", 32'h0, {8'h00, mask});
        chk("tcp_sum_fail_count after reset", 32'h0, {16'h0000, tcp});
        chk("update_stats_flag after reset", 32'h0, {31'h0, flag});
        pulse(24'hFFFFFF, 24'hFFFFFF); // to
        rd(8'hA0, 32'h1, "count after reset");
        finish_test();
    end
endmodule // test_scm_stats_mask
